// >>> design/asp_fifo.sv
// Purpose: Byte FIFO between sample RAM fetch and the sample decoder.
// Assumes: Same clock on both sides; clear empties it in one cycle.
// Notes:   Ready and valid are honest full and not-empty flags.
`timescale 1ns/1ps
module asp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             i_mclk,
    input  wire logic             i_resetn,
    input  wire logic             i_ce,
    input  wire logic             i_clear,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              empty = (wr_ptr == rd_ptr);
    wire              push  = i_in_valid && !full;
    wire              pop   = i_out_ready && !empty;

    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_mclk) begin
        if (i_ce && push) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (i_ce) begin
            if (i_clear) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
            end else begin
                if (push) wr_ptr <= wr_ptr + 1'b1;
                if (pop)  rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // asp_fifo

// >>> design/asp_pkg.sv
// Purpose: Shared constants and types for the audio sample playback engine.
// Assumes: One 20 MHz controller clock; sample RAM is byte wide.
// Notes:   Register indices are word indices on the internal register port.
package asp_pkg;

    localparam int unsigned ASP_CLK_HZ        = 20_000_000;
    localparam logic [32:0] ASP_CLK_HZ_W      = 33'h0_0131_2d00;
    localparam int unsigned ASP_RAM_AW        = 20;
    localparam int unsigned ASP_FIFO_DEPTH    = 16;
    localparam int unsigned ASP_FIFO_WIDTH    = 8;

    localparam logic [3:0] ADDR_START_ADDRESS  = 4'h0;
    localparam logic [3:0] ADDR_LENGTH_BYTES   = 4'h1;
    localparam logic [3:0] ADDR_SAMPLE_RATE    = 4'h2;
    localparam logic [3:0] ADDR_SAMPLE_FORMAT  = 4'h3;
    localparam logic [3:0] ADDR_LOOP_ENABLE    = 4'h4;
    localparam logic [3:0] ADDR_TRIGGER_STATUS = 4'h5;
    localparam logic [3:0] ADDR_VOLUME         = 4'h6;
    localparam logic [3:0] ADDR_FETCH_POINTER  = 4'h7;

    localparam logic [31:0] RST_START_ADDRESS = 32'h0000_0000;
    localparam logic [31:0] RST_LENGTH_BYTES  = 32'h0000_0000;
    localparam logic [31:0] RST_SAMPLE_RATE   = 32'h0000_1f40;
    localparam logic [7:0]  RST_VOLUME        = 8'hff;
    localparam logic [7:0]  PWM_MIDSCALE      = 8'h80;
    localparam logic [6:0]  ADPCM_INDEX_MAX   = 7'h58;
    localparam logic [7:0]  MULAW_BIAS        = 8'h84;

    typedef enum logic [1:0] {
        FORMAT_LINEAR_PCM = 2'b00,
        FORMAT_MU_LAW     = 2'b01,
        FORMAT_ADPCM      = 2'b10
    } asp_fmt_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } asp_reg_req_s;

    localparam logic [14:0] ADPCM_STEP [0:88] = '{
        15'd7, 15'd8, 15'd9, 15'd10, 15'd11, 15'd12, 15'd13, 15'd14, 15'd16, 15'd17,
        15'd19, 15'd21, 15'd23, 15'd25, 15'd28, 15'd31, 15'd34, 15'd37, 15'd41, 15'd45,
        15'd50, 15'd55, 15'd60, 15'd66, 15'd73, 15'd80, 15'd88, 15'd97, 15'd107, 15'd118,
        15'd130, 15'd143, 15'd157, 15'd173, 15'd190, 15'd209, 15'd230, 15'd253, 15'd279, 15'd307,
        15'd337, 15'd371, 15'd408, 15'd449, 15'd494, 15'd544, 15'd598, 15'd658, 15'd724, 15'd796,
        15'd876, 15'd963, 15'd1060, 15'd1166, 15'd1282, 15'd1411, 15'd1552, 15'd1707, 15'd1878,
        15'd2066, 15'd2272, 15'd2499, 15'd2749, 15'd3024, 15'd3327, 15'd3660, 15'd4026, 15'd4428,
        15'd4871, 15'd5358, 15'd5894, 15'd6484, 15'd7132, 15'd7845, 15'd8630, 15'd9493, 15'd10442,
        15'd11487, 15'd12635, 15'd13899, 15'd15289, 15'd16818, 15'd18500, 15'd20350, 15'd22385,
        15'd24623, 15'd27086, 15'd29794, 15'd32767
    };

endpackage

// >>> design/asp_playback.sv
// Purpose: Audio sample playback engine: fetch, decode, scale and PWM out.
// Assumes: Register port and sample RAM port run on i_mclk.
// Notes:   Samples are fetched ahead into a 16-byte FIFO and paced by a rate accumulator.
// Overview of operation
// - Fetching begins at the programmed start address.
// - Length register counts bytes; exactly that many bytes consumed per pass.
// - Samples leave at the programmed rate in hertz.
// - Format register picks linear, mu-law or ADPCM decoding.
// - Loop 0 plays once; loop 1 repeats forever.
// - Any write to the trigger register starts playback, unless the length register is zero.
// - Trigger register reads 1 while playing, 0 when finished.
// - Output is scaled by an 8-bit volume, 0 to 255.
// - Decodes mono 8-bit PCM, 8-bit mu-law or 4-bit IMA ADPCM.
// - ADPCM: low nibble plays first, high nibble second.
// - Current fetch position is readable at any time.
// - Decoded signal drives the PWM audio pin.
`timescale 1ns/1ps
module asp_playback
    import asp_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_ce,
    input  wire asp_reg_req_s          i_reg,
    output logic [31:0]                o_reg_rdata,
    output logic                       o_reg_rvalid,
    output logic                       o_ram_req,
    output logic [ASP_RAM_AW-1:0]      o_ram_addr,
    input  wire logic                  i_ram_ack,
    input  wire logic [7:0]            i_ram_data,
    output logic                       o_audio_pwm,
    output logic                       o_playing
);
    logic [31:0]       start_address;
    logic [31:0]       length_bytes;
    logic [31:0]       sample_rate;
    asp_fmt_e          sample_format;
    logic              loop_enable;
    logic [7:0]        volume;
    logic              playing;
    logic [31:0]       fetch_pointer;
    logic [31:0]       consume_left;
    logic [31:0]       fetch_addr;
    logic [31:0]       fetch_left;
    logic              ram_req;
    logic [31:0]       rate_acc;
    logic              nibble_hi;
    logic signed [15:0] sample;
    logic signed [15:0] predictor;
    logic [6:0]        step_index;
    logic [7:0]        pwm_level;
    logic [7:0]        pwm_count;
    logic              audio_pwm;
    logic [31:0]       reg_rdata;
    logic              reg_rvalid;

    // Register decode.
    wire wr_start   = i_reg.wr && (i_reg.addr == ADDR_START_ADDRESS);
    wire wr_length  = i_reg.wr && (i_reg.addr == ADDR_LENGTH_BYTES);
    wire wr_rate    = i_reg.wr && (i_reg.addr == ADDR_SAMPLE_RATE);
    wire wr_format  = i_reg.wr && (i_reg.addr == ADDR_SAMPLE_FORMAT);
    wire wr_loop    = i_reg.wr && (i_reg.addr == ADDR_LOOP_ENABLE);
    wire wr_volume  = i_reg.wr && (i_reg.addr == ADDR_VOLUME);
    wire trigger    = i_reg.wr && (i_reg.addr == ADDR_TRIGGER_STATUS);

    // FIFO hookup; requests are issued only when there is room, so every
    // returned byte is accepted.
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_byte;
    wire       ram_push = ram_req && i_ram_ack;

    // Sample pacing: the accumulator adds the rate each clock and wraps at
    // the clock frequency, giving rate ticks per second.
    wire [32:0] acc_sum   = {1'b0, rate_acc} + {1'b0, sample_rate};
    wire        rate_tick = playing && (acc_sum >= ASP_CLK_HZ_W);
    wire [32:0] acc_wrap  = acc_sum - ASP_CLK_HZ_W;
    wire        step      = rate_tick && fifo_out_valid;
    wire        is_adpcm  = (sample_format == FORMAT_ADPCM);
    wire        pop       = step && (!is_adpcm || nibble_hi);
    wire        pass_end  = pop && (consume_left == 32'h0000_0001);

    // Mu-law expansion.
    wire [7:0]  mu_inv    = ~fifo_byte;
    wire [15:0] mu_mag_sh = ({8'h00, mu_inv[3:0], 3'b000} + {8'h00, MULAW_BIAS}) << mu_inv[6:4];
    wire [15:0] mu_mag    = mu_mag_sh - {8'h00, MULAW_BIAS};
    wire signed [15:0] mu_sample = mu_inv[7] ? -$signed(mu_mag) : $signed(mu_mag);

    // IMA ADPCM step: low nibble first, then high nibble.
    wire [3:0]  nibble    = nibble_hi ? fifo_byte[7:4] : fifo_byte[3:0];
    wire [14:0] step_size = ADPCM_STEP[step_index];
    wire [16:0] diff      = {5'h00, step_size[14:3]}
                          + (nibble[2] ? {2'b00, step_size} : 17'h00000)
                          + (nibble[1] ? {3'b000, step_size[14:1]} : 17'h00000)
                          + (nibble[0] ? {4'h0, step_size[14:2]} : 17'h00000);
    wire signed [17:0] pred_sum = nibble[3] ? ($signed({{2{predictor[15]}}, predictor}) - $signed({1'b0, diff}))
                                            : ($signed({{2{predictor[15]}}, predictor}) + $signed({1'b0, diff}));
    wire signed [15:0] adpcm_sample = (pred_sum > 18'sh07fff) ? 16'sh7fff :
                                      (pred_sum < -18'sh08000) ? -16'sh8000 : pred_sum[15:0];
    wire signed [7:0]  index_adj = nibble[2] ? $signed({3'b000, nibble[1:0], 1'b0} + 6'h02) : -8'sh01;
    wire signed [8:0]  index_sum = $signed({2'b00, step_index}) + index_adj;
    wire [6:0]         next_step_index = (index_sum < 0) ? 7'h00 :
                                         (index_sum > $signed({2'b00, ADPCM_INDEX_MAX})) ? ADPCM_INDEX_MAX :
                                         index_sum[6:0];

    // Decoder select and volume scaling.
    wire signed [15:0] next_sample = (sample_format == FORMAT_MU_LAW) ? mu_sample :
                                     is_adpcm ? adpcm_sample :
                                     $signed({fifo_byte, 8'h00});
    wire signed [24:0] scaled  = sample * $signed({1'b0, volume});
    wire [7:0]         next_level = scaled[23:16] ^ PWM_MIDSCALE;

    // Read mux.
    wire [31:0] next_rdata =
        (i_reg.addr == ADDR_START_ADDRESS)  ? start_address :
        (i_reg.addr == ADDR_LENGTH_BYTES)   ? length_bytes :
        (i_reg.addr == ADDR_SAMPLE_RATE)    ? sample_rate :
        (i_reg.addr == ADDR_SAMPLE_FORMAT)  ? {30'h0, sample_format} :
        (i_reg.addr == ADDR_LOOP_ENABLE)    ? {31'h0, loop_enable} :
        (i_reg.addr == ADDR_TRIGGER_STATUS) ? {31'h0, playing} :
        (i_reg.addr == ADDR_VOLUME)         ? {24'h0, volume} :
        (i_reg.addr == ADDR_FETCH_POINTER)  ? fetch_pointer : 32'h0000_0000;

    asp_fifo #(
        .WIDTH (ASP_FIFO_WIDTH),
        .DEPTH (ASP_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_resetn    (i_resetn),
        .i_ce        (i_ce),
        .i_clear     (trigger),
        .i_in_valid  (ram_push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (i_ram_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (pop),
        .o_out_data  (fifo_byte)
    );

    // Configuration registers.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            start_address <= RST_START_ADDRESS;
            length_bytes  <= RST_LENGTH_BYTES;
            sample_rate   <= RST_SAMPLE_RATE;
            sample_format <= FORMAT_LINEAR_PCM;
            loop_enable   <= 1'b0;
            volume        <= RST_VOLUME;
        end else if (i_ce) begin
            if (wr_start)  start_address <= i_reg.wdata;
            if (wr_length) length_bytes  <= i_reg.wdata;
            if (wr_rate)   sample_rate   <= i_reg.wdata;
            if (wr_format) sample_format <= asp_fmt_e'(i_reg.wdata[1:0]);
            if (wr_loop)   loop_enable   <= i_reg.wdata[0];
            if (wr_volume) volume        <= i_reg.wdata[7:0];
        end
    end

    // RAM fetch: one byte request at a time, ahead of the decoder.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            fetch_addr <= 32'h0000_0000;
            fetch_left <= 32'h0000_0000;
            ram_req    <= 1'b0;
        end else if (i_ce) begin
            if (trigger) begin
                fetch_addr <= start_address;
                fetch_left <= length_bytes;
                ram_req    <= 1'b0;
            end else if (ram_push) begin
                ram_req <= 1'b0;
                if (fetch_left == 32'h0000_0001 && loop_enable) begin
                    fetch_addr <= start_address;
                    fetch_left <= length_bytes;
                end else begin
                    fetch_addr <= fetch_addr + 32'h0000_0001;
                    fetch_left <= fetch_left - 32'h0000_0001;
                end
            end else if (!ram_req && playing && fetch_left != 32'h0000_0000 && fifo_in_ready) begin
                ram_req <= 1'b1;
            end
        end
    end

    // Playback state, pacing and decoder state. A trigger outranks a pass end.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            playing       <= 1'b0;
            fetch_pointer <= 32'h0000_0000;
            consume_left  <= 32'h0000_0000;
            rate_acc      <= 32'h0000_0000;
            nibble_hi     <= 1'b0;
            predictor     <= 16'sh0000;
            step_index    <= 7'h00;
            sample        <= 16'sh0000;
        end else if (i_ce) begin
            if (trigger) begin
                playing       <= (length_bytes != 32'h0000_0000);
                fetch_pointer <= start_address;
                consume_left  <= length_bytes;
                rate_acc      <= 32'h0000_0000;
                nibble_hi     <= 1'b0;
                predictor     <= 16'sh0000;
                step_index    <= 7'h00;
                sample        <= 16'sh0000;
            end else begin
                rate_acc <= rate_tick ? acc_wrap[31:0] : (playing ? acc_sum[31:0] : 32'h0000_0000);
                if (step) begin
                    sample <= next_sample;
                    if (is_adpcm) begin
                        predictor  <= adpcm_sample;
                        step_index <= next_step_index;
                        nibble_hi  <= !nibble_hi;
                    end
                end
                if (pass_end && loop_enable) begin
                    fetch_pointer <= start_address;
                    consume_left  <= length_bytes;
                    predictor     <= 16'sh0000;
                    step_index    <= 7'h00;
                end else if (pass_end) begin
                    playing       <= 1'b0;
                    sample        <= 16'sh0000;
                    consume_left  <= 32'h0000_0000;
                    fetch_pointer <= fetch_pointer + 32'h0000_0001;
                end else if (pop) begin
                    fetch_pointer <= fetch_pointer + 32'h0000_0001;
                    consume_left  <= consume_left - 32'h0000_0001;
                end
            end
        end
    end

    // PWM output and register read port.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pwm_level  <= PWM_MIDSCALE;
            pwm_count  <= 8'h00;
            audio_pwm  <= 1'b0;
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else if (i_ce) begin
            pwm_level  <= next_level;
            pwm_count  <= pwm_count + 8'h01;
            audio_pwm  <= (pwm_count < pwm_level);
            reg_rvalid <= i_reg.rd;
            if (i_reg.rd) reg_rdata <= next_rdata;
        end
    end

    assign o_ram_req    = ram_req;
    assign o_ram_addr   = fetch_addr[ASP_RAM_AW-1:0];
    assign o_audio_pwm  = audio_pwm;
    assign o_playing    = playing;
    assign o_reg_rdata  = reg_rdata;
    assign o_reg_rvalid = reg_rvalid;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    property p_start_addr;
        i_ce && trigger |=> (fetch_pointer == $past(start_address)) && (fetch_addr == $past(start_address));
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("fetch did not start at start address");

    property p_fetch_bound;
        i_ce && !trigger && fetch_left == 32'h0000_0000 |=> fetch_left == 32'h0000_0000 && !$rose(ram_req);
    endproperty
    a_fetch_bound: assert property (p_fetch_bound) else $error("fetch count exceeds length");

    property p_tick_pace;
        (sample_rate < ASP_CLK_HZ_W[31:1]) && rate_tick && i_ce |=> !rate_tick;
    endproperty
    a_tick_pace: assert property (p_tick_pace) else $error("sample ticks too close");

    property p_linear;
        i_ce && step && sample_format == FORMAT_LINEAR_PCM && !trigger
            |=> sample == ($past(pass_end && !loop_enable) ? 16'sh0000 : $signed({$past(fifo_byte), 8'h00}));
    endproperty
    a_linear: assert property (p_linear) else $error("linear sample decoded wrongly");

    property p_play_once;
        i_ce && pass_end && !loop_enable && !trigger |=> !playing ##1 !playing || trigger;
    endproperty
    a_play_once: assert property (p_play_once) else $error("playback did not stop");

    property p_loop;
        i_ce && pass_end && loop_enable && !trigger |=> playing && fetch_pointer == $past(start_address);
    endproperty
    a_loop: assert property (p_loop) else $error("loop did not restart");

    property p_trigger;
        i_ce && trigger && length_bytes != 32'h0000_0000 |=> playing;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger did not start playback");

    property p_status_read;
        i_ce && i_reg.rd && i_reg.addr == ADDR_TRIGGER_STATUS |=> o_reg_rvalid && o_reg_rdata == {31'h0, $past(playing)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_mute;
        volume == 8'h00 |-> next_level == PWM_MIDSCALE;
    endproperty
    a_mute: assert property (p_mute) else $error("zero volume not silent");

    property p_nibble_pop;
        i_ce && step && is_adpcm && !nibble_hi |-> !pop;
    endproperty
    a_nibble_pop: assert property (p_nibble_pop) else $error("adpcm byte popped after low nibble");

    property p_pointer_read;
        i_ce && i_reg.rd && i_reg.addr == ADDR_FETCH_POINTER |=> o_reg_rdata == $past(fetch_pointer);
    endproperty
    a_pointer_read: assert property (p_pointer_read) else $error("pointer read wrong");

    property p_pwm;
        i_ce |=> o_audio_pwm == ($past(pwm_count) < $past(pwm_level));
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm output wrong");
endmodule // asp_playback

// >>> verif/asp_ram_model.sv
// Purpose: Behavioural sample RAM answering the playback fetch port.
// Assumes: One byte per request; ack is a one-cycle pulse on i_mclk.
// Notes:   Outside an ack the data lines toggle every cycle, never holding the last byte.
`timescale 1ns/1ps
module asp_ram_model (
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    input  wire logic        i_slow,
    input  wire logic        i_req,
    input  wire logic [19:0] i_addr,
    output logic             o_ack,
    output logic [7:0]       o_data
);
    logic [1:0] wait_cnt;
    // Page 2 holds a constant loud byte; elsewhere the byte is the low address.
    function automatic logic [7:0] byte_at(input logic [19:0] a);
        return (a[11:8] == 4'h2) ? 8'h7f : a[7:0];
    endfunction
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_cnt <= 2'h0;
            o_ack    <= 1'b0;
            o_data   <= 8'h00;
        end else if (!o_ack && i_req && (!i_slow || wait_cnt == 2'h3)) begin
            o_ack    <= 1'b1;
            o_data   <= byte_at(i_addr);
            wait_cnt <= 2'h0;
        end else begin
            o_ack    <= 1'b0;
            o_data   <= ~o_data;
            wait_cnt <= (i_req && !o_ack) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule // asp_ram_model

// >>> verif/tb.sv
// Purpose: Self-checking bench for the playback engine through its register port.
// Assumes: Rate 1000000 Hz gives one sample tick every 20 clocks.
// Notes:   Sample RAM is the behavioural model; it can answer at once or slowly.
`timescale 1ns/1ps
module tb;
    import asp_pkg::*;
    logic i_mclk = 1'b0;
    logic i_resetn, i_ce, rvalid, ram_req, ram_ack, audio_pwm, playing, slow, wrapped;
    asp_reg_req_s reg_req;
    logic [31:0] rdata;
    logic [19:0] ram_addr, first_addr;
    logic [7:0] ram_data;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, n_ack = 0;
    asp_playback DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce), .i_reg(reg_req),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_ram_req(ram_req), .o_ram_addr(ram_addr),
        .i_ram_ack(ram_ack), .i_ram_data(ram_data), .o_audio_pwm(audio_pwm), .o_playing(playing));
    asp_ram_model ram (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_slow(slow), .i_req(ram_req),
        .i_addr(ram_addr), .o_ack(ram_ack), .o_data(ram_data));
    always #25 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cyc++;
        if (ram_req && ram_ack) begin
            if (n_ack == 0) first_addr = ram_addr;
            else if (ram_addr == first_addr) wrapped = 1'b1;
            n_ack++;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(negedge i_mclk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_mclk);
        reg_req = '0;
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        @(negedge i_mclk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge i_mclk);
        reg_req = '0;
        chk("read valid", 32'h1, {31'h0, rvalid});
        chk(what, exp, rdata);
    endtask
    task automatic play(input logic [31:0] st, input logic [31:0] len, input logic [1:0] fmt, input logic lp);
        reg_wr(ADDR_START_ADDRESS, st);
        reg_wr(ADDR_LENGTH_BYTES, len);
        reg_wr(ADDR_SAMPLE_FORMAT, {30'h0, fmt});
        reg_wr(ADDR_LOOP_ENABLE, {31'h0, lp});
        n_ack = 0;
        wrapped = 1'b0;
        reg_wr(ADDR_TRIGGER_STATUS, 32'h0);
    endtask
    task automatic wait_idle(output int n);
        n = 0;
        while (playing === 1'b1 && n < 5000) begin
            @(negedge i_mclk);
            n++;
        end
    endtask
    task automatic pwm_high(output int h);
        h = 0;
        repeat (256) begin
            @(negedge i_mclk);
            h += int'(audio_pwm === 1'b1);
        end
    endtask
    initial begin
        int d, s;
        i_ce = 1'b1;
        i_resetn = 1'b0;
        reg_req = '0;
        slow = 1'b0;
        repeat (4) @(negedge i_mclk);
        i_resetn = 1'b1;
        rd_chk("start", ADDR_START_ADDRESS, RST_START_ADDRESS);
        rd_chk("length", ADDR_LENGTH_BYTES, RST_LENGTH_BYTES);
        rd_chk("rate", ADDR_SAMPLE_RATE, RST_SAMPLE_RATE);
        rd_chk("volume", ADDR_VOLUME, {24'h0, RST_VOLUME});
        reg_wr(ADDR_TRIGGER_STATUS, 32'h1);
        rd_chk("status zero length", ADDR_TRIGGER_STATUS, 32'h0);
        reg_wr(ADDR_FETCH_POINTER, 32'h1234);
        rd_chk("pointer", ADDR_FETCH_POINTER, 32'h0);
        reg_wr(4'h9, 32'h55);
        rd_chk("unmapped", 4'h9, 32'h0);
        pwm_high(d);
        chk("idle pwm", 32'd128, 32'(d));
        reg_wr(ADDR_SAMPLE_RATE, 32'd1000000);
        rd_chk("rate", ADDR_SAMPLE_RATE, 32'd1000000);
        $display("test registers done");
        for (int f = 0; f < 3; f++) begin
            play(32'h100, 32'd6, 2'(f), 1'b0);
            rd_chk("status playing", ADDR_TRIGGER_STATUS, 32'h1);
            wait_idle(d);
            s = (f == 2) ? 12 : 6;
            chk("first address", 32'h100, {12'h0, first_addr});
            chk("bytes fetched", 32'd6, 32'(n_ack));
            chk("duration", 32'h1, {31'h0, d >= (s - 2) * 20 && d <= (s + 1) * 20});
            rd_chk("pointer end", ADDR_FETCH_POINTER, 32'h106);
            rd_chk("status done", ADDR_TRIGGER_STATUS, 32'h0);
            $display("test format %0d done", f);
        end
        slow = 1'b1;
        reg_wr(ADDR_VOLUME, 32'h0);
        play(32'h200, 32'd4, FORMAT_LINEAR_PCM, 1'b1);
        repeat (400) @(negedge i_mclk);
        chk("loop playing", 32'h1, {31'h0, playing});
        chk("loop wrapped", 32'h1, {31'h0, wrapped});
        pwm_high(d);
        chk("mute pwm", 32'd128, 32'(d));
        reg_wr(ADDR_VOLUME, 32'hff);
        pwm_high(d);
        chk("loud pwm", 32'h1, {31'h0, d > 128});
        reg_wr(ADDR_LOOP_ENABLE, 32'h0);
        wait_idle(d);
        chk("loop stop", 32'h1, {31'h0, playing === 1'b0 && d <= 100});
        $display("test loop done");
        // A one-byte loop of 0x00 expands to -32124; at full volume the PWM is high 3 clocks in 256.
        play(32'h300, 32'd1, FORMAT_MU_LAW, 1'b1);
        repeat (100) @(negedge i_mclk);
        pwm_high(d);
        chk("mu-law pwm", 32'd3, 32'(d));
        reg_wr(ADDR_LOOP_ENABLE, 32'h0);
        wait_idle(d);
        chk("mu-law stop", 32'h1, {31'h0, playing === 1'b0 && d <= 100});
        $display("test mu-law done");
        final_report();
    end
endmodule // tb
